// file: logic/spc_params.svh
// spc_params.svh: offsets, field positions, reset value and update counts of the
// synthesizer control sequencer.
// assumes: included by bare name from the package and the design module.
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH

// serial frame shape
`define SPC_FRAME_BITS        5'h16
`define SPC_ADDR_BITS         3'h4
`define SPC_DATA_BITS         5'h12

// register addresses
`define SPC_ADDR_MAIN_CFG     4'h0
`define SPC_ADDR_PD_GAIN      4'h1
`define SPC_ADDR_SECT_PWR     4'h2
`define SPC_ADDR_RF1_N        4'h3
`define SPC_ADDR_RF2_N        4'h4
`define SPC_ADDR_IF_N         4'h5
`define SPC_ADDR_RF1_R        4'h6
`define SPC_ADDR_RF2_R        4'h7
`define SPC_ADDR_IF_R         4'h8

// reset value of every written register
`define SPC_REG_RESET         18'h00000

// main configuration fields
`define SPC_CFG_AUX_OUTPUT_SELECT_LSB    12
`define SPC_CFG_IFDIV_LSB     10
`define SPC_CFG_LOW_BIAS_BIT  5
`define SPC_CFG_AUTO_PWR_BIT  3
`define SPC_CFG_AUTO_GAIN_BIT 2

// gain register and power register fields
`define SPC_GAIN_RF1_LSB      0
`define SPC_GAIN_RF2_LSB      2
`define SPC_GAIN_IF_LSB       4
`define SPC_PWR_IF_BIT        1
`define SPC_PWR_RF_BIT        0

// auxiliary output select codes
`define SPC_AUX_FORCE_LOW     2'h1
`define SPC_AUX_NEAR_LIMIT    2'h3

// update-period counts and the rf1 update rate limit
`define SPC_TUNE_UPDATES      6'h0d
`define SPC_SETTLE_UPDATES    6'h19
`define SPC_SETTLE_SLOW_UPD   6'h32
`define SPC_RF1_RATE_LIMIT_HZ 64'h000000000007a120

// prescaler split of n
`define SPC_PRESCALE_BITS     5

`endif

// file: logic/spc_pkg.sv
// spc_pkg: types of the synthesizer control sequencer.
// assumes: spc_params.svh is on the include path.
`include "spc_params.svh"

package spc_pkg;

   typedef enum logic {
      SPC_LOOP_RF = 1'b0,
      SPC_LOOP_IF = 1'b1
   } spc_loop_id_type;

   // per-loop tuning sequencer state
   typedef struct packed {
      logic        on_prev;
      logic        busy;
      logic [17:0] div_cnt;
      logic [5:0]  upd_cnt;
   } spc_loop_type;

   // divider program for the analog counters
   typedef struct packed {
      logic [12:0]                      main_cnt;
      logic [`SPC_PRESCALE_BITS-1:0]    swallow;
      logic [12:0]                      r_div;
   } spc_div_type;

   typedef struct packed {
      logic [1:0] rf1;
      logic [1:0] rf2;
      logic [1:0] ifl;
   } spc_gain_type;

   // registered outputs
   typedef struct packed {
      logic         aux;
      logic         flag;
      logic         if_pwr;
      logic         rf_pwr;
      logic         ref_pwr;
      logic         rf_sel;
      logic         low_bias;
      logic [1:0]   if_out_div;
      logic [1:0]   tuning;
      logic [1:0]   settled;
      logic         rf1_rate_high;
      spc_gain_type gain;
      spc_div_type  rf_div;
      spc_div_type  if_div;
   } spc_out_type;

   // whole module state
   typedef struct packed {
      logic [2:0]        sclk;
      logic [1:0]        sdat;
      logic [2:0]        serial_enable_n;
      logic [1:0]        powerdown_pin;
      logic [2:0]        refc;
      logic [1:0]        near_if;
      logic [1:0]        near_rf;
      logic [21:0]       shift;
      logic [17:0]       cfg;
      logic [17:0]       gain;
      logic [17:0]       pwr;
      logic [17:0]       n_rf1;
      logic [17:0]       n_rf2;
      logic [17:0]       n_if;
      logic [17:0]       r_rf1;
      logic [17:0]       r_rf2;
      logic [17:0]       r_if;
      logic              rf_sel;
      spc_loop_type [1:0] loop;
      spc_out_type       outs;
   } spc_state_type;

endpackage : spc_pkg

// file: logic/spc_sequencer.sv
// spc_sequencer: control logic of a two-RF plus one-IF loop synthesizer:
// serial register port, power control, loop selection, gain choice,
// self-tuning and settling timing, near-limit flag and auxiliary output.
// assumes: all pins are asynchronous to clock_i and are synchronised here;
// the analog loops report their near-limit state as levels.
`timescale 1ns/1ps
`include "spc_params.svh"

module spc_sequencer #(
   parameter int unsigned REF_FREQ_HZ = 13000000
) (
   // clock and reset
   input  wire logic               clock_i,
   input  wire logic               reset_n_i,
   // three-wire serial port
   input  wire logic               serial_clock_i,
   input  wire logic               serial_data_pin_i,
   input  wire logic               serial_enable_n_i,
   // pins and analog indications
   input  wire logic               powerdown_pin_i,
   input  wire logic               reference_input_pin_i,
   input  wire logic               if_near_limit_i,
   input  wire logic               rf_near_limit_i,
   // flag and auxiliary output
   output logic                    auxiliary_output_pin_o,
   output logic                    lock_near_limit_flag_o,
   // power control
   output logic                    if_section_power_o,
   output logic                    rf_section_power_o,
   output logic                    ref_amp_power_o,
   // loop control
   output logic                    rf_loop_select_o,
   output logic                    if_low_bias_o,
   output logic [1:0]              if_output_divide_o,
   output logic [1:0]              tuning_o,
   output logic [1:0]              settled_o,
   output logic                    rf1_rate_high_o,
   output spc_pkg::spc_gain_type   gain_codes_o,
   output spc_pkg::spc_div_type    rf_divider_o,
   output spc_pkg::spc_div_type    if_divider_o
);

   // the whole state sits in one packed struct so that a single
   // register process covers every flop, synchronisers included;
   // the trade is a wide struct, but there is only one reset branch
   spc_pkg::spc_state_type s_r;
   spc_pkg::spc_state_type s_nxt;

   // decoded strobes and per-loop helper levels, all combinational;
   // each one is given a value on every path of the next-state process

   logic        sclk_rise;
   logic        sen_rise;
   logic        ref_rise;
   logic [3:0]  wr_addr;
   logic [17:0] wr_data;
   logic        wr_rf1;
   logic        wr_rf2;
   logic        wr_if;
   logic        pin_on;
   logic        auto_pwr;
   logic [1:0]  sect_on;
   logic [1:0]  trig;
   logic [1:0]  near;
   logic [17:0] r_act;
   logic [17:0] n_rf;
   logic [5:0]  limit;
   logic        rate_high;

   // rf auto gain: 00 below 8192, then steps at 8192, 16384, 32768
   function automatic logic [1:0] gain_rf1(input logic [17:0] n);
      if (n >= 18'h08000) begin
         return 2'h3;
      end else if (n >= 18'h04000) begin
         return 2'h2;
      end else if (n >= 18'h02000) begin
         return 2'h1;
      end
      return 2'h0;
   endfunction

   // rf2 auto gain: steps at 4096, 8192, 16384
   function automatic logic [1:0] gain_rf2(input logic [17:0] n);
      if (n >= 18'h04000) begin
         return 2'h3;
      end else if (n >= 18'h02000) begin
         return 2'h2;
      end else if (n >= 18'h01000) begin
         return 2'h1;
      end
      return 2'h0;
   endfunction

   // if auto gain: steps at 2048, 4096, 8192
   function automatic logic [1:0] gain_if(input logic [17:0] n);
      if (n >= 18'h02000) begin
         return 2'h3;
      end else if (n >= 18'h01000) begin
         return 2'h2;
      end else if (n >= 18'h00800) begin
         return 2'h1;
      end
      return 2'h0;
   endfunction

   // prescaler split: swallow is n modulo the prescale, main the quotient
   function automatic spc_pkg::spc_div_type split(input logic [17:0] n,
                                                  input logic [17:0] r);
      spc_pkg::spc_div_type d;
      d.main_cnt = n[17:`SPC_PRESCALE_BITS];
      d.swallow  = n[`SPC_PRESCALE_BITS-1:0];
      d.r_div    = r[12:0];
      return d;
   endfunction

   // r divisor of the selected rf loop
   function automatic logic [17:0] r_act_rf(input spc_pkg::spc_state_type s);
      return s.rf_sel ? s.r_rf2 : s.r_rf1;
   endfunction

   // whole next-state computation
   // every pin reaches logic only through its second synchroniser flop,
   // so a pin edge shows up two to three system clocks late; serial
   // pulses shorter than about two clocks may therefore be missed,
   // which limits the usable serial clock rate
   always_comb begin
      s_nxt     = s_r;
      wr_addr   = 4'h0;
      wr_data   = 18'h00000;
      wr_rf1    = 1'b0;
      wr_rf2    = 1'b0;
      wr_if     = 1'b0;
      r_act     = 18'h00000;
      limit     = 6'h00;

      // two-flop synchronisers, third stage only for edge finding
      s_nxt.sclk    = {s_r.sclk[1:0], serial_clock_i};
      s_nxt.sdat    = {s_r.sdat[0], serial_data_pin_i};
      s_nxt.serial_enable_n     = {s_r.serial_enable_n[1:0], serial_enable_n_i};
      s_nxt.powerdown_pin    = {s_r.powerdown_pin[0], powerdown_pin_i};
      s_nxt.refc    = {s_r.refc[1:0], reference_input_pin_i};
      s_nxt.near_if = {s_r.near_if[0], if_near_limit_i};
      s_nxt.near_rf = {s_r.near_rf[0], rf_near_limit_i};
      sclk_rise = s_r.sclk[1] & ~s_r.sclk[2];
      sen_rise  = s_r.serial_enable_n[1] & ~s_r.serial_enable_n[2];
      ref_rise  = s_r.refc[1] & ~s_r.refc[2];

      // shifting never looks at power state, so writes land in any mode;
      // the shift register simply keeps the newest 22 bits, so a frame
      // with extra leading bits still lands on the right address
      if (sclk_rise && !s_r.serial_enable_n[1]) begin
         s_nxt.shift = {s_r.shift[20:0], s_r.sdat[1]};
      end

      // frame ends: low four bits are the address, upper eighteen the data
      if (sen_rise) begin
         wr_addr = s_r.shift[3:0];
         wr_data = s_r.shift[21:4];
         unique case (wr_addr)
            `SPC_ADDR_MAIN_CFG: s_nxt.cfg  = wr_data;
            `SPC_ADDR_PD_GAIN:  s_nxt.gain = wr_data;
            `SPC_ADDR_SECT_PWR: s_nxt.pwr  = wr_data;
            `SPC_ADDR_RF1_N: begin
               s_nxt.n_rf1 = wr_data;
               wr_rf1 = 1'b1;
            end
            `SPC_ADDR_RF2_N: begin
               s_nxt.n_rf2 = {1'b0, wr_data[16:0]};
               wr_rf2 = 1'b1;
            end
            `SPC_ADDR_IF_N: begin
               s_nxt.n_if = {2'h0, wr_data[15:0]};
               wr_if = 1'b1;
            end
            `SPC_ADDR_RF1_R: begin
               s_nxt.r_rf1 = {5'h00, wr_data[12:0]};
               wr_rf1 = 1'b1;
            end
            `SPC_ADDR_RF2_R: begin
               s_nxt.r_rf2 = {5'h00, wr_data[12:0]};
               wr_rf2 = 1'b1;
            end
            `SPC_ADDR_IF_R: begin
               s_nxt.r_if = {5'h00, wr_data[12:0]};
               wr_if = 1'b1;
            end
            default: begin
               // reserved addresses are dropped
            end
         endcase
      end

      // last written rf divisor picks the rf loop and output buffer source
      if (wr_rf1) begin
         s_nxt.rf_sel = 1'b0;
      end else if (wr_rf2) begin
         s_nxt.rf_sel = 1'b1;
      end

      // power: pin low wins, auto bit acts as both section bits set
      pin_on   = s_r.powerdown_pin[1];
      auto_pwr = s_r.cfg[`SPC_CFG_AUTO_PWR_BIT];
      sect_on[spc_pkg::SPC_LOOP_IF] = pin_on &
         (auto_pwr | s_r.pwr[`SPC_PWR_IF_BIT]);
      sect_on[spc_pkg::SPC_LOOP_RF] = pin_on &
         (auto_pwr | s_r.pwr[`SPC_PWR_RF_BIT]);

      // a new frequency while powered, or a power-up, restarts tuning;
      // a rewrite with an unchanged value also retunes, which is harmless
      // and saves comparing against the old divisor
      trig[spc_pkg::SPC_LOOP_RF] = wr_rf1 | wr_rf2 |
         ~s_r.loop[spc_pkg::SPC_LOOP_RF].on_prev;
      trig[spc_pkg::SPC_LOOP_IF] = wr_if |
         ~s_r.loop[spc_pkg::SPC_LOOP_IF].on_prev;

      // rf1 update rate above the limit when reference / r exceeds it
      rate_high = (64'(s_r.r_rf1) * `SPC_RF1_RATE_LIMIT_HZ)
                  < 64'(REF_FREQ_HZ);
      s_nxt.outs.rf1_rate_high = rate_high;

      near[spc_pkg::SPC_LOOP_IF] = s_r.near_if[1];
      near[spc_pkg::SPC_LOOP_RF] = s_r.near_rf[1];
      n_rf = s_r.rf_sel ? s_r.n_rf2 : s_r.n_rf1;

      // per-loop tuning and settling sequencer
      // the update counter saturates at its limit, so settled stays high
      // until power goes off or a new trigger restarts the count
      for (int i = 0; i < 2; i++) begin
         if (i == int'(spc_pkg::SPC_LOOP_RF)) begin
            r_act = s_r.rf_sel ? s_r.r_rf2 : s_r.r_rf1;
            limit = `SPC_TUNE_UPDATES + ((rate_high && !s_r.rf_sel) ?
                    `SPC_SETTLE_SLOW_UPD : `SPC_SETTLE_UPDATES);
         end else begin
            r_act = s_r.r_if;
            limit = `SPC_TUNE_UPDATES + `SPC_SETTLE_UPDATES;
         end
         s_nxt.loop[i].on_prev = sect_on[i];
         if (!sect_on[i]) begin
            s_nxt.loop[i].busy    = 1'b0;
            s_nxt.loop[i].div_cnt = 18'h00000;
            s_nxt.loop[i].upd_cnt = 6'h00;
         end else if (trig[i]) begin
            s_nxt.loop[i].busy    = 1'b1;
            s_nxt.loop[i].div_cnt = 18'h00000;
            s_nxt.loop[i].upd_cnt = 6'h00;
         end else if (s_r.loop[i].busy && ref_rise) begin
            // r of zero behaves as one so the counter cannot stall
            if ((s_r.loop[i].div_cnt + 18'h00001) >= r_act) begin
               s_nxt.loop[i].div_cnt = 18'h00000;
               if (s_r.loop[i].upd_cnt < limit) begin
                  s_nxt.loop[i].upd_cnt = s_r.loop[i].upd_cnt + 6'h01;
               end
            end else begin
               s_nxt.loop[i].div_cnt = s_r.loop[i].div_cnt + 18'h00001;
            end
         end
         s_nxt.outs.tuning[i] = s_nxt.loop[i].busy &&
            (s_nxt.loop[i].upd_cnt < `SPC_TUNE_UPDATES);
         s_nxt.outs.settled[i] = s_nxt.loop[i].busy &&
            (s_nxt.loop[i].upd_cnt >= limit);
      end

      // near-limit flag: tuning or a powered loop past tuning near its limit
      s_nxt.outs.flag =
         s_nxt.outs.tuning[spc_pkg::SPC_LOOP_IF] |
         s_nxt.outs.tuning[spc_pkg::SPC_LOOP_RF] |
         (sect_on[spc_pkg::SPC_LOOP_IF] & near[spc_pkg::SPC_LOOP_IF]) |
         (sect_on[spc_pkg::SPC_LOOP_RF] & near[spc_pkg::SPC_LOOP_RF]);

      // auxiliary pin: flag on 11, low for 01 and the reserved codes
      unique case (s_r.cfg[`SPC_CFG_AUX_OUTPUT_SELECT_LSB +: 2])
         `SPC_AUX_NEAR_LIMIT: s_nxt.outs.aux = s_nxt.outs.flag;
         `SPC_AUX_FORCE_LOW:  s_nxt.outs.aux = 1'b0;
         default:             s_nxt.outs.aux = 1'b0;
      endcase

      // gain codes: register copy or choice from n
      // auto gain reads the stored n of each loop, not only the active
      // rf loop, so both rf codes stay ready for a band switch
      if (s_r.cfg[`SPC_CFG_AUTO_GAIN_BIT]) begin
         s_nxt.outs.gain.rf1 = gain_rf1(s_r.n_rf1);
         s_nxt.outs.gain.rf2 = gain_rf2(s_r.n_rf2);
         s_nxt.outs.gain.ifl = gain_if(s_r.n_if);
      end else begin
         s_nxt.outs.gain.rf1 = s_r.gain[`SPC_GAIN_RF1_LSB +: 2];
         s_nxt.outs.gain.rf2 = s_r.gain[`SPC_GAIN_RF2_LSB +: 2];
         s_nxt.outs.gain.ifl = s_r.gain[`SPC_GAIN_IF_LSB +: 2];
      end

      // divider programs for the analog counters
      s_nxt.outs.rf_div = split(n_rf, r_act_rf(s_r));
      s_nxt.outs.if_div = split(s_r.n_if, s_r.r_if);

      // remaining control levels
      s_nxt.outs.if_pwr     = sect_on[spc_pkg::SPC_LOOP_IF];
      s_nxt.outs.rf_pwr     = sect_on[spc_pkg::SPC_LOOP_RF];
      s_nxt.outs.ref_pwr    = pin_on & (auto_pwr | (s_r.pwr[`SPC_PWR_IF_BIT] &
                              s_r.pwr[`SPC_PWR_RF_BIT]));
      s_nxt.outs.rf_sel     = s_r.rf_sel;
      s_nxt.outs.low_bias   = s_r.cfg[`SPC_CFG_LOW_BIAS_BIT];
      s_nxt.outs.if_out_div = s_r.cfg[`SPC_CFG_IFDIV_LSB +: 2];
   end

   // state register; everything resets to zero, so both sections start off;
   // the enable synchroniser starts at its idle high level so that no false
   // frame commit follows the release of reset
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_r     <= '0;
         s_r.serial_enable_n <= 3'h7;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from the state register; no output passes
   // through any gate after its flop, so pins never glitch
   assign auxiliary_output_pin_o = s_r.outs.aux;
   assign lock_near_limit_flag_o = s_r.outs.flag;
   assign if_section_power_o     = s_r.outs.if_pwr;
   assign rf_section_power_o     = s_r.outs.rf_pwr;
   assign ref_amp_power_o        = s_r.outs.ref_pwr;
   assign rf_loop_select_o       = s_r.outs.rf_sel;
   assign if_low_bias_o          = s_r.outs.low_bias;
   assign if_output_divide_o     = s_r.outs.if_out_div;
   assign tuning_o               = s_r.outs.tuning;
   assign settled_o              = s_r.outs.settled;
   assign rf1_rate_high_o        = s_r.outs.rf1_rate_high;
   assign gain_codes_o           = s_r.outs.gain;
   assign rf_divider_o           = s_r.outs.rf_div;
   assign if_divider_o           = s_r.outs.if_div;

endmodule // spc_sequencer

// file: test/spc_sequencer_props.sv
// spc_sequencer_props: port-level timing relations of the control sequencer.
// assumes: bound onto spc_sequencer; a single clock domain.
`timescale 1ns/1ps
module spc_sequencer_props (
   // clock and reset
   input wire logic       clock_i,
   input wire logic       reset_n_i,
   // pins and analog indications
   input wire logic       powerdown_pin_i,
   input wire logic       if_near_limit_i,
   input wire logic       rf_near_limit_i,
   // watched outputs
   input wire logic       auxiliary_output_pin_o,
   input wire logic       lock_near_limit_flag_o,
   input wire logic       if_section_power_o,
   input wire logic       rf_section_power_o,
   input wire logic       ref_amp_power_o,
   input wire logic [1:0] tuning_o,
   input wire logic [1:0] settled_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);
   // the pin outranks every register bit; 5 cycles covers the synchroniser
   a_pin_forces_off: assert property (
      !powerdown_pin_i [*5] |-> !if_section_power_o && !rf_section_power_o && !ref_amp_power_o)
      else $error("section powered while powerdown pin low");
   a_ref_needs_both: assert property (
      ref_amp_power_o |-> if_section_power_o && rf_section_power_o)
      else $error("reference amplifier on without both sections");
   a_power_starts_tune: assert property (
      $rose(if_section_power_o) |-> ##[0:2] tuning_o[1])
      else $error("if power-up did not start tuning");
   a_tune_min_span: assert property (
      $rose(tuning_o[0]) |-> tuning_o[0] [*8])
      else $error("rf tuning shorter than 8 cycles");
   a_tune_raises_flag: assert property (
      (|tuning_o) |-> lock_near_limit_flag_o)
      else $error("flag low while a loop tunes");
   a_flag_quiet: assert property (
      (tuning_o == 2'h0 && !if_near_limit_i && !rf_near_limit_i) [*5]
      |-> !lock_near_limit_flag_o)
      else $error("flag high with no cause");
   a_near_if_flag: assert property (
      (if_near_limit_i && if_section_power_o) [*5] |-> lock_near_limit_flag_o)
      else $error("if near-limit not on flag");
   a_settle_after_tune: assert property (
      $rose(settled_o[0]) |-> !tuning_o[0] && !$past(tuning_o[0], 8))
      else $error("rf settled too soon after tuning");
   // aux is registered from the same flag value in the same cycle; the check still allows one cycle of lag
   a_aux_only_flag: assert property (
      auxiliary_output_pin_o |-> lock_near_limit_flag_o || $past(lock_near_limit_flag_o))
      else $error("aux high without the flag");
endmodule // spc_sequencer_props

bind spc_sequencer spc_sequencer_props u_spc_sequencer_props (
   .clock_i               (clock_i),
   .reset_n_i             (reset_n_i),
   .powerdown_pin_i       (powerdown_pin_i),
   .if_near_limit_i       (if_near_limit_i),
   .rf_near_limit_i       (rf_near_limit_i),
   .auxiliary_output_pin_o(auxiliary_output_pin_o),
   .lock_near_limit_flag_o(lock_near_limit_flag_o),
   .if_section_power_o    (if_section_power_o),
   .rf_section_power_o    (rf_section_power_o),
   .ref_amp_power_o       (ref_amp_power_o),
   .tuning_o              (tuning_o),
   .settled_o             (settled_o)
);

// file: test/spc_host_model.sv
// spc_host_model: host controller writing 22-bit frames over the serial link.
// assumes: clock_i is the 40 MHz system clock; serial clock idles low.
`timescale 1ns/1ps
module spc_host_model (
   // system clock
   input  wire logic clock_i,
   // serial pins toward the sequencer
   output logic      serial_clock_o,
   output logic      serial_data_o,
   output logic      serial_enable_n_o
);
   initial begin
      serial_clock_o = 1'b0;
      serial_data_o = 1'b0;
      serial_enable_n_o = 1'b1;
   end
   // four system clocks a half period gives the 200 ns serial period
   task automatic half();
      repeat (4) @(posedge clock_i);
      #1;
   endtask
   // junk bits first, then data msb first, then address
   task automatic send(input logic [3:0] addr, input logic [17:0] data,
                       input logic [7:0] junk, input int n_junk);
      logic [29:0] word;
      word = {junk, data, addr};
      serial_enable_n_o = 1'b0;
      for (int i = 21 + n_junk; i >= 0; i--) begin
         serial_clock_o = 1'b0;
         serial_data_o = word[i];
         half();
         serial_clock_o = 1'b1;
         half();
      end
      serial_clock_o = 1'b0;
      // a released line must not keep showing the last bit
      serial_data_o = ~serial_data_o;
      half();
      serial_enable_n_o = 1'b1;
      half();
   endtask
endmodule // spc_host_model

// file: test/spc_sequencer_test.sv
// spc_sequencer_test: self-checking bench of the control sequencer.
// assumes: host model drives the serial pins; reference pin is made here.
`timescale 1ns/1ps
`include "spc_params.svh"
module spc_sequencer_test;
   localparam int REF_HZ = 32'h000f4240;
   logic                  clock_i = 1'b0;
   logic                  reset_n_i = 1'b0;
   logic                  sclk, sdat, sen_n;
   logic                  powerdown_pin = 1'b0;
   logic                  ref_pin = 1'b0;
   logic                  if_near = 1'b0;
   logic                  rf_near = 1'b0;
   logic                  aux, flag, if_pwr, rf_pwr, ref_pwr, rf_sel, low_bias, rate_hi;
   logic [1:0]            ifdiv, tuning, settled;
   spc_pkg::spc_gain_type gain;
   spc_pkg::spc_div_type  rf_div, if_div;
   int                    n_errors = 0;
   int                    n_tests = 0;
   logic [31:0]           seed = 32'h0000ff1c;
   logic [17:0]           n, g;
   int                    t_tune, t_set, e;
   int                    rv[2] = '{3, 1};
   logic [17:0]           corner[11] = '{18'h007ff, 18'h00800, 18'h00fff, 18'h01000,
      18'h01fff, 18'h02000, 18'h03fff, 18'h04000, 18'h07fff, 18'h08000, 18'h3ffff};

   always #12.5 clock_i = ~clock_i;
   // reference pin: one rising edge every four system clocks
   always begin
      repeat (2) @(posedge clock_i);
      #1;
      ref_pin = ~ref_pin;
   end

   spc_host_model u_spc_host_model (.clock_i(clock_i), .serial_clock_o(sclk),
      .serial_data_o(sdat), .serial_enable_n_o(sen_n));
   spc_sequencer #(.REF_FREQ_HZ(REF_HZ)) u_spc_sequencer (
      .clock_i(clock_i), .reset_n_i(reset_n_i), .serial_clock_i(sclk),
      .serial_data_pin_i(sdat), .serial_enable_n_i(sen_n), .powerdown_pin_i(powerdown_pin),
      .reference_input_pin_i(ref_pin), .if_near_limit_i(if_near),
      .rf_near_limit_i(rf_near), .auxiliary_output_pin_o(aux),
      .lock_near_limit_flag_o(flag), .if_section_power_o(if_pwr),
      .rf_section_power_o(rf_pwr), .ref_amp_power_o(ref_pwr),
      .rf_loop_select_o(rf_sel), .if_low_bias_o(low_bias), .if_output_divide_o(ifdiv),
      .tuning_o(tuning), .settled_o(settled), .rf1_rate_high_o(rate_hi),
      .gain_codes_o(gain), .rf_divider_o(rf_div), .if_divider_o(if_div));

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic clk(input int c);
      repeat (c) @(posedge clock_i);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [17:0] d);
      u_spc_host_model.send(a, d, 8'h00, 0);
      clk(8);
   endtask
   // bounded wait until both loops report settled
   task automatic wait_settled();
      for (int t = 0; t < 3000 && settled !== 2'h3; t++) clk(1);
   endtask
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // gain code from n against half the loop's lowest threshold step
   function automatic logic [1:0] kp(input logic [17:0] v, input logic [17:0] t);
      return (v >= 8 * t) ? 2'h3 : (v >= 4 * t) ? 2'h2 : (v >= 2 * t) ? 2'h1 : 2'h0;
   endfunction
   // retune through an rf1 reference write and time tuning and settling
   task automatic measure(input int r);
      u_spc_host_model.send(4'h6, 18'(r), 8'h00, 0);
      clk(2);
      t_tune = 0;
      for (t_set = 0; t_set < 2000 && settled[0] !== 1'b1; t_set++) begin
         clk(1);
         if (tuning[0] === 1'b1) t_tune = t_set;
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // a hang costs far less than this span of nearly four times the run
   initial begin
      repeat (80000) @(posedge clock_i);
      n_errors++;
      report_and_stop();
   end

   initial begin
      clk(5);
      reset_n_i = 1'b1;
      clk(2);
      chk("reset outs", {aux, flag, if_pwr, rf_pwr, ref_pwr, tuning, settled, gain}, 0);
      // every pin, auto and section bit combination; writes land with the pin low too
      for (int i = 0; i < 16; i++) begin
         wr(4'h0, {4'h0, 2'h3, 8'h00, i[2], 3'h0});
         wr(4'h2, {16'h0000, i[1:0]});
         powerdown_pin = i[3];
         clk(8);
         chk("if power", if_pwr, i[3] & (i[2] | i[1]));
         chk("rf power", rf_pwr, i[3] & (i[2] | i[0]));
         chk("ref amp", ref_pwr, i[3] & (i[2] | (i[1] & i[0])));
      end
      $display("test power table done");
      // low bias only because the assumed load is 500 ohms or more
      wr(4'h0, 18'h03c20);
      chk("cfg copy", {low_bias, ifdiv}, 3'h7);
      wr(4'h0, 18'h03000);
      wr(4'h2, 18'h00003);
      foreach (rv[k]) begin
         measure(rv[k]);
         chk("rate high", rate_hi, rv[k] * 32'h0007a120 < REF_HZ);
         chk("rf select", rf_sel, 1'b0);
         e = `SPC_TUNE_UPDATES * rv[k] * 4;
         chk("tune span", 32'(t_tune > e - rv[k] * 4 - 12 && t_tune < e + 12), 1);
         e = (`SPC_TUNE_UPDATES + ((rv[k] * 32'h0007a120 < REF_HZ) ?
             `SPC_SETTLE_SLOW_UPD : `SPC_SETTLE_UPDATES)) * rv[k] * 4;
         chk("settle span", 32'(t_set > e - rv[k] * 4 - 12 && t_set < e + 12), 1);
      end
      $display("test tuning timing done");
      wr(4'h0, 18'h03004);
      for (int i = 0; i < 19; i++) begin
         n = (i < 11) ? corner[i] : 18'(xs());
         wr(4'h3, n);
         chk("rf1 gain", gain.rf1, kp(n, 18'h01000));
         chk("rf select", rf_sel, 1'b0);
         wr(4'h4, n);
         chk("rf2 gain", gain.rf2, kp({1'b0, n[16:0]}, 18'h00800));
         chk("rf select", rf_sel, 1'b1);
         wr(4'h5, n);
         chk("if gain", gain.ifl, kp({2'h0, n[15:0]}, 18'h00400));
      end
      u_spc_host_model.send(4'h3, 18'h04000, 8'(xs()), 8);
      clk(8);
      chk("leading bits", gain.rf1, 2'h2);
      wr(4'h9, 18'h00000);
      chk("reserved addr", gain.rf1, 2'h2);
      $display("test auto gain done");
      wr(4'h0, 18'h03000);
      for (int i = 0; i < 6; i++) begin
         g = 18'(xs());
         wr(4'h1, g);
         chk("manual gain", gain, {g[1:0], g[3:2], g[5:4]});
      end
      $display("test manual gain done");
      wait_settled();
      chk("settled flag", {flag, aux}, 2'h0);
      if_near = 1'b1;
      clk(8);
      chk("if near", {flag, aux}, 2'h3);
      wr(4'h0, 18'h01000);
      chk("aux low", {flag, aux}, 2'h2);
      wr(4'h0, 18'h03000);
      if_near = 1'b0;
      rf_near = 1'b1;
      clk(8);
      chk("rf near", {flag, aux}, 2'h3);
      // the host answers the raised flag by retuning both loops
      wr(4'h5, 18'h00800);
      chk("if retune", tuning[1], 1'b1);
      rf_near = 1'b0;
      wr(4'h3, 18'h00800);
      chk("rf retune", tuning[0], 1'b1);
      chk("rf divider", rf_div, {13'h0040, 5'h00, 13'h0001});
      chk("if divider", if_div, {13'h0040, 5'h00, 13'h0000});
      wait_settled();
      chk("quiet flag", {flag, aux, settled}, 4'h3);
      $display("test near limit done");
      report_and_stop();
   end
endmodule // spc_sequencer_test
